// >>> verilog/mdsp_top.sv
// Serial command and status port of a multi-channel half-bridge motor driver.
// Assumes an external master drives chip select, serial clock and serial input.
`timescale 1ns/10ps
module mdsp_top (
  input  wire logic                I_CLK_SYS,
  input  wire logic                I_RESET_N,
  input  wire logic                I_CHIP_SELECT_N,
  input  wire logic                I_SCLK,
  input  wire logic                I_SI,
  input  wire mdsp_pkg::mdsp_fault_s I_FAULT,
  output wire logic                O_SO,
  output wire logic                O_SO_OE,
  output wire logic [11:0]         O_SWITCH,
  output wire mdsp_pkg::mdsp_fault_s O_FLAGS
);

  // Synchronised pin levels and their edges, bit 2 chip select, 1 clock, 0 data.
  wire logic [2:0] pin_lvl;
  wire logic [2:0] pin_rise;
  wire logic [2:0] pin_fall;
  wire logic [2:0] fault_lvl;

  // Pins idle with chip select high so reset release makes no false frame start.
  mdsp_sync_edge #(
    .WIDTH     (3),
    .RESET_VAL (mdsp_pkg::PIN_RESET)
  ) u_pin_sync (
    .i_clk     (I_CLK_SYS),
    .i_reset_n (I_RESET_N),
    .i_async   ({I_CHIP_SELECT_N, I_SCLK, I_SI}),
    .o_level   (pin_lvl),
    .o_rise    (pin_rise),
    .o_fall    (pin_fall)
  );

  // Fault conditions are analog levels; only their synchronised level is used.
  mdsp_sync_edge #(
    .WIDTH     (3),
    .RESET_VAL (3'h0)
  ) u_fault_sync (
    .i_clk     (I_CLK_SYS),
    .i_reset_n (I_RESET_N),
    .i_async   (I_FAULT),
    .o_level   (fault_lvl),
    .o_rise    (),
    .o_fall    ()
  );

  mdsp_pkg::mdsp_state_e state_ff;
  mdsp_pkg::mdsp_state_e nxt_state;
  mdsp_pkg::mdsp_fault_s flag_ff;
  mdsp_pkg::mdsp_fault_s nxt_flag;
  mdsp_pkg::mdsp_fault_s fault_s;
  logic [15:0]           rx_ff;
  logic [15:0]           tx_ff;
  logic                  so_ff;
  logic [4:0]            cnt_ff;
  logic [12:0]           cmd_ff;
  logic [11:0]           drive_ff;

  wire logic        cs_n_s;
  wire logic        cs_fall;
  wire logic        cs_rise;
  wire logic        sclk_rise;
  wire logic        sclk_fall;
  wire logic        si_s;
  wire logic        st_idle;
  wire logic        st_active;
  wire logic        st_commit;
  wire logic        start;
  wire logic        shift_in;
  wire logic        shift_out;
  wire logic        len_ok;
  wire logic        commit_ok;
  wire logic        full_rst;
  wire logic [2:0]  flag_clr;
  wire logic        any_flag;
  wire logic [15:0] reply_w;
  wire logic [15:0] nxt_rx;
  wire logic [15:0] nxt_tx;
  wire logic        nxt_so;
  wire logic [4:0]  nxt_cnt;
  wire logic [12:0] nxt_cmd;
  wire logic [11:0] nxt_drive;

  // Pin decode.
  assign cs_n_s    = pin_lvl[2];
  assign cs_fall   = pin_fall[2];
  assign cs_rise   = pin_rise[2];
  assign sclk_rise = pin_rise[1];
  assign sclk_fall = pin_fall[1];
  assign si_s      = pin_lvl[0];
  assign fault_s   = fault_lvl;

  // Sequencer decode; clock and data outside an open frame are ignored.
  assign st_idle   = (state_ff == mdsp_pkg::ST_IDLE);
  assign st_active = (state_ff == mdsp_pkg::ST_ACTIVE);
  assign st_commit = (state_ff == mdsp_pkg::ST_COMMIT);
  assign start     = st_idle & cs_fall;
  assign shift_in  = st_active & sclk_fall & ~cs_rise;

  // The first rise has no preceding fall and must not shift, or bit 15 is lost.
  assign shift_out = st_active & sclk_rise & (cnt_ff != mdsp_pkg::CNT_RESET);

  // Frame state transitions.
  always_comb begin
    case (state_ff)
      mdsp_pkg::ST_IDLE:   nxt_state = cs_fall ? mdsp_pkg::ST_ACTIVE : mdsp_pkg::ST_IDLE;
      mdsp_pkg::ST_ACTIVE: nxt_state = cs_rise ? mdsp_pkg::ST_COMMIT : mdsp_pkg::ST_ACTIVE;
      mdsp_pkg::ST_COMMIT: nxt_state = mdsp_pkg::ST_IDLE;
      default:             nxt_state = mdsp_pkg::ST_IDLE;
    endcase
  end

  // Receive path: MSB first, so each fall shifts left and appends the pin.
  assign nxt_rx  = shift_in ? {rx_ff[14:0], si_s} : rx_ff;
  assign nxt_cnt = start ? mdsp_pkg::CNT_RESET :
                   (shift_in && cnt_ff != mdsp_pkg::CNT_SAT) ? cnt_ff + 5'h01 : cnt_ff;

  // Reply word: sticky flags on top, real bridge C switch states, then commands.
  assign reply_w = {flag_ff.overvoltage_flag, flag_ff.thermal_flag,
                    flag_ff.overcurrent_flag, drive_ff[11:8], cmd_ff[8:0]};

  // Transmit path: load the reply at frame start, move one bit per rise after the first.
  assign nxt_tx = start ? reply_w : shift_out ? {tx_ff[14:0], 1'b0} : tx_ff;
  assign nxt_so = start ? reply_w[mdsp_pkg::BIT_OV] : shift_out ? tx_ff[14] : so_ff;

  // Commit decode; a frame with a bad length has no effect at all.
  assign len_ok    = mdsp_pkg::mdsp_len_ok(cnt_ff);
  assign commit_ok = st_commit & len_ok;
  assign full_rst  = commit_ok & rx_ff[mdsp_pkg::BIT_FULL] & rx_ff[mdsp_pkg::BIT_OV];
  assign flag_clr  = {3{commit_ok}} & ({rx_ff[mdsp_pkg::BIT_OV], rx_ff[mdsp_pkg::BIT_OT],
                                        rx_ff[mdsp_pkg::BIT_OC]} | {3{full_rst}});
  assign nxt_cmd   = full_rst ? mdsp_pkg::CMD_RESET :
                     commit_ok ? rx_ff[12:0] : cmd_ff;

  // A live fault beats a clear arriving in the same cycle, so no event is lost.
  assign nxt_flag  = fault_s | (flag_ff & ~flag_clr);
  assign any_flag  = |nxt_flag;

  // Any set flag forces every switch off; clearing the flag lets them return.
  assign nxt_drive = nxt_cmd[mdsp_pkg::BIT_SW_HI:mdsp_pkg::BIT_SW_LO]
                     & {mdsp_pkg::SW_COUNT{~any_flag}};

  // Sequencer and serial registers.
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_ff <= mdsp_pkg::ST_IDLE;
      rx_ff    <= mdsp_pkg::WORD_RESET;
      tx_ff    <= mdsp_pkg::WORD_RESET;
      so_ff    <= 1'b0;
      cnt_ff   <= mdsp_pkg::CNT_RESET;
    end else begin
      state_ff <= nxt_state;
      rx_ff    <= nxt_rx;
      tx_ff    <= nxt_tx;
      so_ff    <= nxt_so;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Status registers and switch drive.
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cmd_ff   <= mdsp_pkg::CMD_RESET;
      flag_ff  <= 3'h0;
      drive_ff <= mdsp_pkg::SW_RESET;
    end else begin
      cmd_ff   <= nxt_cmd;
      flag_ff  <= nxt_flag;
      drive_ff <= nxt_drive;
    end
  end

  // Output enable follows the open frame, so it lags the pin by the sync delay.
  assign O_SO     = so_ff;
  assign O_SO_OE  = st_active;
  assign O_SWITCH = drive_ff;
  assign O_FLAGS  = flag_ff;

  // Checks next to the logic they guard.
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);

  a_idle_no_capture: assert property (st_idle |=> $stable(rx_ff))
    else $error("receive register changed outside a frame");
  a_rx_capture: assert property (shift_in |=> rx_ff == {$past(rx_ff[14:0]), $past(si_s)})
    else $error("input bit not captured at clock fall");
  a_so_on_rise: assert property (shift_out |=> so_ff == $past(tx_ff[14]))
    else $error("serial output not advanced at clock rise");
  a_so_msb_first: assert property (start |=> so_ff == $past(reply_w[15]) ##1 O_SO_OE)
    else $error("first reply bit is not bit 15");
  a_commit_copy: assert property (commit_ok && !full_rst |=>
                                  cmd_ff == $past(rx_ff[12:0])
                                  ##1 O_SWITCH == ($past(cmd_ff[12:1], 1)
                                  & {12{~|$past(flag_ff, 1)}}))
    else $error("status copy or switch drive wrong after commit");
  a_oe_only_low: assert property (cs_n_s [*2] |-> !O_SO_OE)
    else $error("serial output driven while chip select high");
  a_bad_len_hold: assert property (st_commit && !len_ok |=>
                                   $stable(cmd_ff) && $stable(O_SWITCH))
    else $error("bad length frame changed status");
  a_ov_clear: assert property (commit_ok && rx_ff[15] && !fault_s.overvoltage_flag |=>
                               !flag_ff.overvoltage_flag)
    else $error("overvoltage flag not cleared");
  a_full_reset: assert property (full_rst |=> cmd_ff == 13'h0000 ##1 O_SWITCH == 12'h000)
    else $error("full status reset not applied");
  a_flag_sticky: assert property (flag_ff.thermal_flag && !st_commit |=>
                                  flag_ff.thermal_flag)
    else $error("thermal flag dropped without a clear");
  a_count_restart: assert property (start |=> cnt_ff == 5'h00)
    else $error("bit count not restarted at frame start");

  c_good_frame: cover property (commit_ok && !full_rst);
  c_bad_frame:  cover property (st_commit && !len_ok);
  c_full_reset: cover property (full_rst);
  c_ov_cleared: cover property (flag_ff.overvoltage_flag ##1 !flag_ff.overvoltage_flag);

endmodule : mdsp_top

// >>> verilog/mdsp_pkg.sv
// Constants, state encoding and carrier types for the motor driver serial port.
// Assumes a single 100 MHz system clock that oversamples the serial pins.
package mdsp_pkg;

  // Frame geometry and the accepted window of clocked bits per frame.
  localparam int             FRAME_BITS = 16;
  localparam int             CNT_W      = 5;
  localparam logic [4:0]     MIN_BITS   = 5'h0F;
  localparam logic [4:0]     MAX_BITS   = 5'h11;
  localparam logic [4:0]     CNT_SAT    = 5'h12;
  localparam logic [4:0]     CNT_RESET  = 5'h00;

  // Bit positions inside a command or reply word.
  localparam int             BIT_OV     = 15;
  localparam int             BIT_OT     = 14;
  localparam int             BIT_OC     = 13;
  localparam int             BIT_FULL   = 0;
  localparam int             BIT_SW_LO  = 1;
  localparam int             BIT_SW_HI  = 12;
  localparam int             SW_COUNT   = 12;
  localparam int             BIT_C_LO   = 9;
  localparam int             CMD_W      = 13;

  // Values after reset.
  localparam logic [15:0]    WORD_RESET = 16'h0000;
  localparam logic [12:0]    CMD_RESET  = 13'h0000;
  localparam logic [11:0]    SW_RESET   = 12'h000;
  localparam logic [2:0]     PIN_RESET  = 3'h4;

  // Frame sequencer states, Gray coded along idle, active, commit.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_COMMIT = 2'b11
  } mdsp_state_e;

  // Fault condition inputs and the matching sticky flags.
  typedef struct packed {
    logic overvoltage_flag;
    logic thermal_flag;
    logic overcurrent_flag;
  } mdsp_fault_s;

  // A frame is kept only when its clocked bit count lies inside the window.
  function automatic logic mdsp_len_ok(input logic [4:0] cnt);
    return (cnt >= MIN_BITS) && (cnt <= MAX_BITS);
  endfunction : mdsp_len_ok

endpackage : mdsp_pkg

// >>> verilog/mdsp_sync_edge.sv
// Two-stage synchroniser with edge detection for a group of slow inputs.
// Assumes inputs are asynchronous to i_clk and change far slower than it.
`timescale 1ns/10ps
module mdsp_sync_edge #(
  parameter int               WIDTH     = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_async,
  output wire logic [WIDTH-1:0] o_level,
  output wire logic [WIDTH-1:0] o_rise,
  output wire logic [WIDTH-1:0] o_fall
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] prev_ff;

  // The first stage feeds only the second; edges compare stages two and three.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
      prev_ff <= RESET_VAL;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Edge pulses last one system clock each.
  assign o_level = sync_ff;
  assign o_rise  = sync_ff & ~prev_ff;
  assign o_fall  = ~sync_ff & prev_ff;

endmodule : mdsp_sync_edge

// >>> tb/mdsp_master.sv
// SPI master model that frames commands for the motor driver serial port.
// Assumes the bench clock paces it; the serial clock rests low between frames except during noise.
`timescale 1ns/10ps
module mdsp_master (
  input  wire logic i_clk,
  input  wire logic i_so,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_si
);
  // Idle pin levels follow the pull-up on select and the pull-downs elsewhere.
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_si   = 1'b0;
  end

  // Waits whole system cycles, then moves off the edge by the bench delay.
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick

  // Toggles clock and data with select high, which the port must not count.
  task automatic noise(input int n);
    repeat (n) begin
      o_sclk = 1'b1;
      o_si   = ~o_si;
      tick(8);
      o_sclk = 1'b0;
      tick(8);
    end
    o_si = 1'b0;
  endtask : noise

  // Sends the bits in order and samples the reply just before each fall.
  // The reply is returned raw, since the port never flags a bad frame.
  task automatic frame(input logic q[$], output logic r[$]);
    r = {};
    o_cs_n = 1'b0;
    tick(8);
    foreach (q[k]) begin
      o_sclk = 1'b1;
      o_si   = q[k];
      tick(8);
      r.push_back(i_so);
      o_sclk = 1'b0;
      tick(8);
    end
    o_cs_n = 1'b1;
    o_si   = 1'b0;
    tick(12);
  endtask : frame
endmodule : mdsp_master

// >>> tb/mdsp_top_tb.sv
// Self-checking bench for the motor driver serial port.
// Assumes the master model in this folder and the design package are compiled first.
`timescale 1ns/10ps
module mdsp_top_tb;
  logic                  clk;
  logic                  rst_n;
  logic                  cs_n;
  logic                  sclk;
  logic                  si;
  logic                  so;
  logic                  so_oe;
  logic [11:0]           sw;
  mdsp_pkg::mdsp_fault_s fault;
  mdsp_pkg::mdsp_fault_s flags;
  logic [15:0]           rx;
  logic [12:0]           cmd;
  logic [2:0]            fl;
  logic [31:0]           seed;
  int                    n_fail;
  int                    check_count;

  // The wire floats whenever the port releases it, so a missing drive shows up.
  wire so_wire = so_oe ? so : 1'bz;

  mdsp_top i_mdsp_top (
    .I_CLK_SYS       (clk),
    .I_RESET_N       (rst_n),
    .I_CHIP_SELECT_N (cs_n),
    .I_SCLK          (sclk),
    .I_SI            (si),
    .I_FAULT         (fault),
    .O_SO            (so),
    .O_SO_OE         (so_oe),
    .O_SWITCH        (sw),
    .O_FLAGS         (flags)
  );

  mdsp_master i_mdsp_master (
    .i_clk  (clk),
    .i_so   (so_wire),
    .o_cs_n (cs_n),
    .o_sclk (sclk),
    .o_si   (si)
  );

  // Compares with case equality so an unknown or floating value never matches.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // The single verdict; a run that made no comparison cannot pass.
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // Next value of the stimulus shift register.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Sends the low n bits of w, checks the reply, then models the commit.
  task automatic send(input logic [19:0] w, input int n);
    logic        q[$];
    logic        r[$];
    logic [15:0] rep;
    q   = {};
    rep = {fl, cmd[12:9] & {4{~|fl}}, cmd[8:0]};
    for (int k = n - 1; k >= 0; k--) q.push_back(w[k]);
    i_mdsp_master.frame(q, r);
    foreach (q[k]) begin
      if (k < 16) chk(r[k], rep[15-k]);
      rx = {rx[14:0], q[k]};
    end
    // Only a count inside the window reaches the status register.
    if (n >= 15 && n <= 17) begin
      fl  = fl & ~rx[15:13];
      cmd = rx[12:0];
      if (rx[0] && rx[15]) begin
        cmd = '0;
        fl  = '0;
      end
      fl = fl | fault;
    end
    chk(so_oe, 1'b0);
    chk(sw, cmd[12:1] & {12{~|fl}});
    chk(flags, fl);
  endtask : send

  // Holds a fault long enough to pass the synchroniser, then drops it.
  task automatic pulse(input logic [2:0] f);
    fault = f;
    i_mdsp_master.tick(10);
    fault = '0;
    fl    = fl | f;
    i_mdsp_master.tick(4);
    chk(flags, fl);
    chk(sw, 12'h000);
  endtask : pulse

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // A hang counts as a mismatch and still ends in the closing report.
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    close_out();
  end

  // Main sequence: corner cases first, then random frames.
  initial begin
    rst_n = 1'b0;
    fault = '0;
    seed  = 32'h2484;
    rx    = '0;
    cmd   = '0;
    fl    = '0;
    n_fail      = 0;
    check_count = 0;
    i_mdsp_master.tick(16);
    rst_n = 1'b1;
    i_mdsp_master.tick(1);
    chk(sw, 12'h000);
    chk(flags, 3'h0);
    chk(so_oe, 1'b0);
    send(20'h01FFE, 16);
    i_mdsp_master.noise(4);
    send(20'h00AAA, 16);
    send(20'h05555, 14);
    send(20'hF1555, 18);
    send(20'h01554, 16);
    // A reset in mid-run must clear switches and flags and drop the output enable.
    rst_n = 1'b0;
    i_mdsp_master.tick(3);
    chk(sw, 12'h000);
    chk(flags, 3'h0);
    chk(so_oe, 1'b0);
    rst_n = 1'b1;
    rx    = '0;
    cmd   = '0;
    fl    = '0;
    i_mdsp_master.tick(2);
    send(20'h00F0E, 15);
    send(20'h10C36, 17);
    pulse(3'h1);
    send(20'h01FFE, 16);
    send(20'h03FFE, 16);
    pulse(3'h4);
    send(20'h09FFE, 16);
    pulse(3'h2);
    send(20'h05FFE, 16);
    // A fault still present during a clearing frame wins, so its flag stays set.
    fault = 3'h1;
    i_mdsp_master.tick(4);
    fl    = 3'h1;
    send(20'h03FFE, 16);
    fault = '0;
    send(20'h08001, 16);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      send(seed[19:0], (seed[23:20] == 4'h0) ? 14 : 16 + int'(seed[24]));
    end
    close_out();
  end
endmodule : mdsp_top_tb
